//--- hdl/cld_core.sv
// decode and execute for the eight-bit load group
`timescale 1ns/1ns
// Notes on behaviour
// - fd 36: store immediate at index plus displacement
// - indexed immediate store takes 4,4,3,5,3 states
// - 0a loads accumulator from counter pair address
// - 1a loads accumulator from destination pair address
// - 3a loads accumulator from absolute address
// - address operand low byte first
// - 02 stores accumulator at counter pair address
// - 12 stores accumulator at destination pair address
// - 32 stores accumulator at absolute address
// - ed 57 copies vector page to accumulator
// - ed 5f copies refresh counter to accumulator
// - those two set s,z; clear h,n; keep c
// - those two copy shadow interrupt enable to p/v
// - interrupt during them leaves p/v zero
// - ed 47 copies accumulator to vector page
// - all other loads leave flags alone
module cld_core
   import cld_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic [15:0] counter_register_pair,
   input wire logic [15:0] destination_register_pair,
   input wire logic [15:0] second_index_register,
   input wire logic interrupt_enable_shadow_ff,
   input wire logic int_taken,
   output logic [7:0] acc,
   output logic [7:0] flags,
   output logic [7:0] vec_page,
   output logic [7:0] refresh,
   output logic [15:0] pc,
   output logic instr_done
);
   import cld_pkg::*;

   cld_phase_t phase; // current machine cycle kind
   cld_phase_t next_phase;
   logic [7:0] op; // opcode after any prefix
   logic [7:0] next_op;
   logic [7:0] tmp; // displacement or low address byte
   logic [7:0] next_tmp;
   logic [15:0] addr; // address of the current machine cycle
   logic [15:0] next_addr;
   logic [7:0] wdata; // byte to be written
   logic [7:0] next_wdata;
   logic [7:0] next_acc;
   logic [7:0] next_flags;
   logic [7:0] next_vec_page;
   logic [7:0] next_refresh;
   logic [15:0] next_pc;
   logic next_done;
   logic int_seen; // interrupt accepted inside this instruction
   logic next_int_seen;
   logic [2:0] cyc_len; // states in this machine cycle
   logic tlast; // last state of this machine cycle
   logic [7:0] spec_val; // value moved by a special load
   logic [7:0] spec_flags; // flags after a special load
   logic [7:0] rfr_inc; // refresh counter after this fetch

   // length of a machine cycle by its kind
   function automatic logic [2:0] phase_len(input cld_phase_t ph);
      logic [2:0] n;
      n = LEN_MEM;
      unique case (ph)
         PH_FETCH, PH_FETCH_IDX: n = LEN_FETCH;
         PH_FETCH_EXT: n = LEN_FETCH_EXT;
         PH_IMM: n = LEN_IMM_CALC;
         PH_DISP, PH_ADDR_LO, PH_ADDR_HI, PH_READ, PH_WRITE: n = LEN_MEM;
      endcase
      return n;
   endfunction

   // low seven bits count opcode fetches, bit 7 is held
   function automatic logic [7:0] rfr_step(input logic [7:0] r);
      return {r[7], 7'(r[6:0] + 7'h01)};
   endfunction

   // sign extended displacement added to a base
   function automatic logic [15:0] add_disp(input logic [15:0] base, input logic [7:0] d);
      return 16'(base + {{8{d[7]}}, d});
   endfunction

   assign cyc_len = phase_len(phase);

   cld_tstate_timer #(
      .W(3)
   ) u_timer (
      .clk(clk),
      .rst_b(rst_b),
      .len(cyc_len),
      .last(tlast)
   );

   // the source of a special accumulator load; op still holds the prefix, so decode the bus byte
   assign spec_val = (mem_rdata == OP_LD_A_VEC) ? vec_page : rfr_inc;

   cld_spec_flags u_flags (
      .value(spec_val),
      .old_flags(flags),
      .shadow_ff(interrupt_enable_shadow_ff),
      .int_hit(int_seen | int_taken),
      .new_flags(spec_flags)
   );

   assign rfr_inc = rfr_step(refresh);

   // bus strobes follow the kind of machine cycle
   always_comb
   begin
      mem_addr = addr;
      mem_wdata = wdata;
      mem_wr = (phase == PH_WRITE);
      mem_rd = (phase != PH_WRITE);
   end

   // sequencing of machine cycles; data is taken in the last state
   always_comb
   begin
      next_phase = phase;
      next_op = op;
      next_tmp = tmp;
      next_addr = addr;
      next_wdata = wdata;
      next_acc = acc;
      next_flags = flags;
      next_vec_page = vec_page;
      next_refresh = refresh;
      next_pc = pc;
      next_done = 1'b0;
      // set wins over the clear at an instruction start
      next_int_seen = int_seen | int_taken;
      if (tlast)
      begin
         unique case (phase)
            PH_FETCH:
            begin
               next_op = mem_rdata;
               next_refresh = rfr_inc;
               next_pc = 16'(pc + 16'h0001);
               next_addr = 16'(pc + 16'h0001);
               next_phase = PH_FETCH;
               unique case (mem_rdata)
                  OP_PREFIX_IDX2: next_phase = PH_FETCH_IDX;
                  OP_PREFIX_EXT: next_phase = PH_FETCH_EXT;
                  OP_LD_A_BCP:
                  begin
                     next_addr = counter_register_pair;
                     next_phase = PH_READ;
                  end
                  OP_LD_A_DEP:
                  begin
                     next_addr = destination_register_pair;
                     next_phase = PH_READ;
                  end
                  OP_ST_A_BCP:
                  begin
                     next_addr = counter_register_pair;
                     next_wdata = acc;
                     next_phase = PH_WRITE;
                  end
                  OP_ST_A_DEP:
                  begin
                     next_addr = destination_register_pair;
                     next_wdata = acc;
                     next_phase = PH_WRITE;
                  end
                  OP_LD_A_ABS, OP_ST_A_ABS: next_phase = PH_ADDR_LO;
                  default:
                  begin
                     // anything else outside this group passes as one fetch
                     next_done = 1'b1;
                     next_int_seen = int_taken;
                  end
               endcase
            end
            PH_FETCH_IDX:
            begin
               // second opcode fetch of the prefixed form
               next_op = mem_rdata;
               next_refresh = rfr_inc;
               next_pc = 16'(pc + 16'h0001);
               next_addr = 16'(pc + 16'h0001);
               if (mem_rdata == OP_ST_IDX_IMM)
                  next_phase = PH_DISP;
               else
               begin
                  next_phase = PH_FETCH;
                  next_done = 1'b1;
                  next_int_seen = int_taken;
               end
            end
            PH_FETCH_EXT:
            begin
               // five-state fetch carries out the register move itself
               next_op = mem_rdata;
               next_refresh = rfr_inc;
               next_pc = 16'(pc + 16'h0001);
               next_addr = 16'(pc + 16'h0001);
               next_phase = PH_FETCH;
               next_done = 1'b1;
               next_int_seen = int_taken;
               unique case (mem_rdata)
                  OP_LD_A_VEC:
                  begin
                     next_acc = vec_page;
                     next_flags = spec_flags;
                  end
                  OP_LD_A_RFR:
                  begin
                     next_acc = rfr_inc;
                     next_flags = spec_flags;
                  end
                  OP_LD_VEC_A: next_vec_page = acc;
                  OP_LD_RFR_A: next_refresh = acc;
                  default:
                  begin
                     // other extended codes are not part of this group
                     next_flags = flags;
                  end
               endcase
            end
            PH_DISP:
            begin
               next_tmp = mem_rdata;
               next_pc = 16'(pc + 16'h0001);
               next_addr = 16'(pc + 16'h0001);
               next_phase = PH_IMM;
            end
            PH_IMM:
            begin
               // two extra states cover the address addition
               next_wdata = mem_rdata;
               next_pc = 16'(pc + 16'h0001);
               next_addr = add_disp(second_index_register, tmp);
               next_phase = PH_WRITE;
            end
            PH_ADDR_LO:
            begin
               next_tmp = mem_rdata;
               next_pc = 16'(pc + 16'h0001);
               next_addr = 16'(pc + 16'h0001);
               next_phase = PH_ADDR_HI;
            end
            PH_ADDR_HI:
            begin
               next_pc = 16'(pc + 16'h0001);
               next_addr = {mem_rdata, tmp};
               if (op == OP_LD_A_ABS)
                  next_phase = PH_READ;
               else
               begin
                  next_wdata = acc;
                  next_phase = PH_WRITE;
               end
            end
            PH_READ:
            begin
               next_acc = mem_rdata;
               next_addr = pc;
               next_phase = PH_FETCH;
               next_done = 1'b1;
               next_int_seen = int_taken;
            end
            PH_WRITE:
            begin
               // write completes; memory has taken the byte
               next_addr = pc;
               next_phase = PH_FETCH;
               next_done = 1'b1;
               next_int_seen = int_taken;
            end
            default:
            begin
               // illegal code recovers to a fresh fetch
               next_addr = pc;
               next_phase = PH_FETCH;
            end
         endcase
      end
   end

   // register the architectural and sequencing state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase <= PH_FETCH;
         op <= 8'h00;
         tmp <= 8'h00;
         addr <= RST_PC;
         wdata <= 8'h00;
         acc <= RST_ACC;
         flags <= RST_FLAGS;
         vec_page <= RST_VEC;
         refresh <= RST_RFR;
         pc <= RST_PC;
         instr_done <= 1'b0;
         int_seen <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         op <= next_op;
         tmp <= next_tmp;
         addr <= next_addr;
         wdata <= next_wdata;
         acc <= next_acc;
         flags <= next_flags;
         vec_page <= next_vec_page;
         refresh <= next_refresh;
         pc <= next_pc;
         instr_done <= next_done;
         int_seen <= next_int_seen;
      end
   end
endmodule

//--- hdl/cld_pkg.sv
// constants for the eight-bit load decode and execute block
package cld_pkg;
   // opcodes handled by this block
   localparam logic [7:0] OP_PREFIX_IDX2 = 8'hfd;
   localparam logic [7:0] OP_PREFIX_EXT = 8'hed;
   localparam logic [7:0] OP_ST_IDX_IMM = 8'h36;
   localparam logic [7:0] OP_LD_A_BCP = 8'h0a;
   localparam logic [7:0] OP_LD_A_DEP = 8'h1a;
   localparam logic [7:0] OP_LD_A_ABS = 8'h3a;
   localparam logic [7:0] OP_ST_A_BCP = 8'h02;
   localparam logic [7:0] OP_ST_A_DEP = 8'h12;
   localparam logic [7:0] OP_ST_A_ABS = 8'h32;
   localparam logic [7:0] OP_LD_A_VEC = 8'h57;
   localparam logic [7:0] OP_LD_A_RFR = 8'h5f;
   localparam logic [7:0] OP_LD_VEC_A = 8'h47;
   localparam logic [7:0] OP_LD_RFR_A = 8'h4f;
   // clock states per machine cycle kind
   localparam logic [2:0] LEN_FETCH = 3'h4;
   localparam logic [2:0] LEN_FETCH_EXT = 3'h5;
   localparam logic [2:0] LEN_MEM = 3'h3;
   localparam logic [2:0] LEN_IMM_CALC = 3'h5;
   // flag bit positions
   localparam int FLAG_S = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_H = 4;
   localparam int FLAG_PV = 2;
   localparam int FLAG_N = 1;
   localparam int FLAG_C = 0;
   // reset values
   localparam logic [15:0] RST_PC = 16'h0000;
   localparam logic [7:0] RST_ACC = 8'hff;
   localparam logic [7:0] RST_FLAGS = 8'hff;
   localparam logic [7:0] RST_VEC = 8'h00;
   localparam logic [7:0] RST_RFR = 8'h00;
   // machine cycle kinds
   typedef enum logic [3:0] {
      PH_FETCH = 4'h0,
      PH_FETCH_IDX = 4'h1,
      PH_FETCH_EXT = 4'h2,
      PH_DISP = 4'h3,
      PH_IMM = 4'h4,
      PH_ADDR_LO = 4'h5,
      PH_ADDR_HI = 4'h6,
      PH_READ = 4'h7,
      PH_WRITE = 4'h8
   } cld_phase_t;
endpackage

//--- hdl/cld_tstate_timer.sv
// counts clock states inside one machine cycle
`timescale 1ns/1ns
module cld_tstate_timer #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] len,
   output logic last
);
   logic [W-1:0] cnt; // state index within the cycle
   logic [W-1:0] next_cnt;

   // last state of the cycle; the caller swaps len at the same edge
   always_comb
   begin
      last = (cnt == len - W'(1));
      next_cnt = last ? '0 : cnt + W'(1);
   end

   // register the state index
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end
endmodule

//--- hdl/cld_spec_flags.sv
// flag result of the accumulator loads from vector page or refresh
`timescale 1ns/1ns
module cld_spec_flags
   import cld_pkg::*;
(
   input wire logic [7:0] value,
   input wire logic [7:0] old_flags,
   input wire logic shadow_ff,
   input wire logic int_hit,
   output logic [7:0] new_flags
);
   // sign, zero from value; h and n cleared; carry kept
   always_comb
   begin
      new_flags = old_flags;
      new_flags[FLAG_S] = value[7];
      new_flags[FLAG_Z] = (value == 8'h00);
      new_flags[FLAG_H] = 1'b0;
      new_flags[FLAG_N] = 1'b0;
      // an accepted interrupt forces the copy to zero
      new_flags[FLAG_PV] = int_hit ? 1'b0 : shadow_ff;
   end
endmodule

//--- testbench/cld_core_sva.sv
// assertions on the ports of the load decode core
`timescale 1ns/1ns
module cld_core_sva
   import cld_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] acc,
   input wire logic [7:0] flags,
   input wire logic [7:0] vec_page,
   input wire logic [7:0] refresh,
   input wire logic instr_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // a cycle reads or writes, never both
   a_rd_wr_excl: assert property (!(mem_rd && mem_wr))
      else $error("read and write together");
   // write cycle is three states
   a_wr_three_states: assert property ($rose(mem_wr) |-> mem_wr [*3] ##1 !mem_wr)
      else $error("write length wrong");
   // bus held through a write
   a_wr_bus_held: assert property (mem_wr && $past(mem_wr) |->
      $stable(mem_addr) && $stable(mem_wdata)) else $error("write bus moved");
   // shortest instruction is four states
   a_done_spacing: assert property (instr_done |=> !instr_done [*3])
      else $error("end pulses too close");
   // carry never touched
   a_carry_kept: assert property ($stable(flags[FLAG_C]))
      else $error("carry changed");
   // a flag update clears half carry and subtract
   a_hn_cleared: assert property ($changed(flags) |-> !flags[FLAG_H] && !flags[FLAG_N])
      else $error("half carry or subtract set");
   // results land only as an instruction ends
   a_result_at_end: assert property ($changed(acc) || $changed(flags) |-> instr_done)
      else $error("result mid instruction");
   // vector page only takes the accumulator
   a_vec_from_acc: assert property ($changed(vec_page) |->
      instr_done && vec_page == $past(acc)) else $error("vector page source wrong");
   // refresh top bit moves only by a load from the accumulator
   a_rfr_top_load: assert property ($changed(refresh[7]) |-> refresh[7] == $past(acc[7]))
      else $error("refresh top bit moved");
endmodule
bind cld_core cld_core_sva chk (.clk(clk), .rst_b(rst_b), .mem_addr(mem_addr),
   .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
   .vec_page(vec_page), .refresh(refresh), .instr_done(instr_done));

//--- testbench/cld_mem_model.sv
// byte memory on the far side of the core's bus
`timescale 1ns/1ns
module cld_mem_model (
   input wire logic clk,
   input wire logic [15:0] addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] m [0:65535]; // cleared: unused code reads as opcode 00, which passes as one fetch
   logic [15:0] la = 16'h0000; // last write address
   logic [7:0] ld = 8'h00; // last write byte
   int nw = 0; // write cycles seen
   logic pw = 1'b0; // write high last state
   initial foreach (m[i]) m[i] = 8'h00;
   // no wait states; an unread bus shows the inverse, never a stale match
   assign rdata = rd ? m[addr] : ~m[addr];
   // store each write state, count each write cycle once
   always @(posedge clk)
   begin
      if (wr)
      begin
         m[addr] <= wdata;
         la <= addr;
         ld <= wdata;
      end
      if (wr && !pw)
         nw <= nw + 1;
      pw <= wr;
   end
endmodule

//--- testbench/testbench.sv
// self-checking bench for the load decode core
`timescale 1ns/1ns
module testbench;
   import cld_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0; // low for ten cycles
   logic [15:0] cnt_pair = 16'h0000, dst_pair = 16'h0000; // counter and destination pairs
   logic [15:0] idx_reg = 16'h0000, t = 16'h0000; // second index, absolute target
   logic sh = 1'b0, it = 1'b0, itk = 1'b0; // shadow, interrupt plan, interrupt pin
   logic [15:0] ma, pc;
   logic rd, wr, done;
   logic [7:0] wd, rdat, acc, flags, vp, rf;
   logic [7:0] a_e = 8'hff, f_e = 8'hff, v_e = 8'h00, r_e = 8'h00, x, d; // expected
   int n_errors = 0, tests_run = 0;
   integer seed = 81;
   always #4 clk = ~clk;
   cld_core uut (.clk(clk), .rst_b(rst_b), .mem_addr(ma), .mem_rd(rd), .mem_wr(wr),
      .mem_wdata(wd), .mem_rdata(rdat), .counter_register_pair(cnt_pair),
      .destination_register_pair(dst_pair), .second_index_register(idx_reg),
      .interrupt_enable_shadow_ff(sh), .int_taken(itk), .acc(acc), .flags(flags),
      .vec_page(vp), .refresh(rf), .pc(pc), .instr_done(done));
   cld_mem_model mem (.clk(clk), .addr(ma), .rd(rd), .wr(wr), .wdata(wd), .rdata(rdat));
   // compare and count
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask
   // flags after a special accumulator load; interrupt forces parity low
   function automatic logic [7:0] spf(input logic [7:0] o, input logic [7:0] v);
      spf = {v[7], v == 8'h00, o[5], 1'b0, o[3], sh & !it, 1'b0, o[0]};
   endfunction
   // place bytes at the fetch address, run one instruction, compare
   task automatic exec(input logic [7:0] b0, b1, b2, input int nb, ln,
      input int we, input logic [15:0] ta, input logic [7:0] td);
      logic [15:0] a;
      int n;
      int w0;
      a = ma;
      w0 = mem.nw;
      mem.m[a] = b0;
      mem.m[a + 16'h1] = b1;
      mem.m[a + 16'h2] = b2;
      mem.m[a + 16'h3] = td;
      itk = it;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         itk = 1'b0;
         n++;
      end while (!done && n < 40);
      $display("opcode %h %h took %0d states", b0, b1, n);
      chk("states", 16'(ln), 16'(n));
      chk("next fetch", a + 16'(nb), ma);
      chk("pc", a + 16'(nb), pc);
      chk("writes", 16'(w0 + we), 16'(mem.nw));
      if (we == 1)
      begin
         chk("write address", ta, mem.la);
         chk("write data", {8'h00, td}, {8'h00, mem.ld});
      end
      chk("acc", {8'h00, a_e}, {8'h00, acc});
      chk("vector page", {8'h00, v_e}, {8'h00, vp});
      chk("flags", {8'h00, f_e & 8'hd7}, {8'h00, flags & 8'hd7});
   endtask
   // accumulator load from memory
   task automatic ldm(input logic [15:0] p, input logic [7:0] op, input int nb);
      mem.m[p] = x;
      a_e = x;
      exec(op, t[7:0], t[15:8], nb, (nb == 3) ? 13 : 7, 0, 16'h0000, 8'h00);
   endtask
   // two byte extended opcode
   task automatic ed(input logic [7:0] op);
      exec(8'hed, op, 8'h00, 2, 9, 0, 16'h0000, 8'h00);
   endtask
   // one instruction of the table
   task automatic run_op(input int k);
      case (k)
         0: exec(8'hfd, 8'h36, d, 4, 19, 1, idx_reg + {{8{d[7]}}, d}, x);
         1: ldm(cnt_pair, 8'h0a, 1);
         2: ldm(dst_pair, 8'h1a, 1);
         3: ldm(t, 8'h3a, 3);
         4: exec(8'h02, 8'h00, 8'h00, 1, 7, 1, cnt_pair, a_e);
         5: exec(8'h12, 8'h00, 8'h00, 1, 7, 1, dst_pair, a_e);
         6: exec(8'h32, t[7:0], t[15:8], 3, 13, 1, t, a_e);
         7:
         begin
            v_e = a_e;
            ed(8'h47);
         end
         8:
         begin
            a_e = v_e;
            f_e = spf(f_e, v_e);
            ed(8'h57);
         end
         9:
         begin
            r_e = a_e;
            ed(8'h4f);
            chk("refresh", {8'h00, r_e}, {8'h00, rf});
         end
         10:
         begin
            a_e = {r_e[7], r_e[6:0] + 7'h02};
            f_e = spf(f_e, a_e);
            ed(8'h5f);
            chk("refresh", {8'h00, a_e}, {8'h00, rf});
         end
         11: ed(8'h00);
         12: exec(8'hfd, 8'h00, 8'h00, 2, 8, 0, 16'h0000, 8'h00);
         default: exec(8'h00, 8'h00, 8'h00, 1, 4, 0, 16'h0000, 8'h00);
      endcase
   endtask
   // verdict and end of run
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard, far beyond the fewer than a thousand states of the run
   initial
   begin
      #100000;
      n_errors++;
      report_and_stop;
   end
   // reset, then rounds of every opcode; rounds 0 and 1 use zero and sign values
   initial
   begin
      repeat (10) @(posedge clk);
      #1;
      chk("reset acc flags", {RST_ACC, RST_FLAGS}, {acc, flags});
      chk("reset vec refresh", {RST_VEC, RST_RFR}, {vp, rf});
      rst_b = 1'b1;
      while (!done)
      begin
         @(posedge clk);
         #1;
      end
      for (int r = 0; r < 6; r++)
      begin
         for (int k = 0; k < 14; k++)
         begin
            x = (r == 0) ? 8'h00 : (r == 1) ? 8'h80 : 8'($random(seed));
            d = 8'($random(seed));
            cnt_pair = {1'b1, 15'($random(seed))};
            dst_pair = {1'b1, 15'($random(seed))};
            idx_reg = {4'h9, 12'($random(seed))};
            t = {1'b1, 15'($random(seed))};
            sh = 1'($random(seed));
            it = (r == 2);
            run_op(k);
         end
      end
      report_and_stop;
   end
endmodule
